// [ptc_pkg.sv]
// constants, types and helper functions of the passive tag core
// Contract
// - storage is 32 blocks of 32 bits
// - blocks 0-2 device, 3-29 user, 30-31 reserved
// - whole-block read and write by command only
// - blocks write-protectable; block 0 bits 30-31 free
// - talk-first plus fast-read sends fast-read after power-up
// - talk-first clear means silence until valid command
// - Manchester answer at 70 kHz from internal time base
// - decode pulse-position symbols and gap pulses
// - calibration pulse times the command decoder
// - modulator on while answer level high
// - modulate only inside own time slot
// - detect and report torn block writes
// - 32-bit tag identifier never changed by writes
// - commands and answers carry a CRC; the fast-read gap command carries none
// - internal 70 kHz tick times all but decoding; the code times them on the 140 kHz half-bit tick
// - symbol 2.8 ms normal, 160 us fast
// - block programming takes 5 ms after last symbol
package ptc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ    = 20_000_000;          // ref_clk rate
  localparam int BIT_HZ    = 70_000;              // answer bit rate
  localparam int HALF_HZ   = 2 * BIT_HZ;          // manchester half-bit rate
  localparam int HALF_CYC  = CLK_HZ / HALF_HZ;    // divider, rounded down
  localparam int WRITE_US  = 5000;                // block programming time
  localparam int WRITE_HT  = (WRITE_US * HALF_HZ + 999_999) / 1_000_000;
  localparam int SLOT_US   = 2500;                // anti-collision slot
  localparam int SLOT_HT   = SLOT_US * HALF_HZ / 1_000_000;
  localparam int FRGAP_US  = 175;                 // fast-read gap width
  localparam int FRGAP_CYC = FRGAP_US * (CLK_HZ / 1_000_000);
  localparam int SYMN_US   = 2800;                // normal symbol width
  localparam int SYMF_US   = 160;                 // fast symbol width
  localparam int SYMN_CYC  = SYMN_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W     = $clog2(2 * SYMN_CYC); // decoder counter width
  localparam int HT_W      = 13;                  // half-tick timer width

  ////////////////////////////////////////////////////////////////////////////
  // memory map
  localparam int NBLK       = 32;                 // blocks
  localparam int BLK_W      = 32;                 // bits per block
  localparam int CFG_BLK    = 0;                  // configuration block
  localparam int TAG_BLK    = 1;                  // factory tag identifier
  localparam int USER_FIRST = 3;                  // first user block
  localparam int RSV_FIRST  = 30;                 // first reserved block
  localparam int FR_WORDS   = 6;                  // fast read, 96 bits
  localparam int BLK_WORDS  = 2;                  // one block, 32 bits
  localparam int TF_POS     = 0;                  // talk_first_bit
  localparam int FR_POS     = 1;                  // fast_read_bit
  localparam int MULTI_POS  = 2;                  // multi-tag slotting on
  localparam int SLOTN_POS  = 3;                  // 4-bit own slot number
  localparam logic [31:0] B0_FREE   = 32'hC000_0000; // never protected
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // factory config

  ////////////////////////////////////////////////////////////////////////////
  // command frame
  localparam logic [3:0]  OP_READ   = 4'h1;       // read one block
  localparam logic [3:0]  OP_WRITE  = 4'h2;       // write one block
  localparam logic [3:0]  OP_LOCK   = 4'h3;       // protect one block
  localparam logic [4:0]  SHORT_NIB = 5'h07;      // op, addr, crc
  localparam logic [4:0]  LONG_NIB  = 5'h0F;      // op, addr, data, crc
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;   // crc seed
  localparam logic [15:0] CRC_POLY  = 16'h1021;   // crc polynomial
  localparam int          WORD_W    = 16;         // answer fifo word
  localparam int          FIFO_D    = 8;          // answer fifo depth

  // core states
  typedef enum logic [3:0] {
    S_BOOT, S_IDLE, S_GAP, S_CAL, S_SYM, S_SLOT, S_PUSH, S_DRAIN, S_WRITE
  } ptc_state_t;

  // decoded command carried from the frame to the executor
  typedef struct packed {
    logic [3:0]  op;   // opcode
    logic [4:0]  blk;  // block address
    logic [31:0] data; // write data
  } ptc_cmd_t;

  // crc over one nibble, msb first
  function automatic logic [15:0] ptc_crc_nib(input logic [15:0] crc,
                                              input logic [3:0]  nib);
    logic [15:0] c;
    c = crc;
    for (int i = 3; i >= 0; i--) begin
      if (c[15] ^ nib[i]) c = {c[14:0], 1'b0} ^ CRC_POLY;
      else c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // crc over one answer word, msb nibble first
  function automatic logic [15:0] ptc_crc_word(input logic [15:0] crc,
                                               input logic [15:0] w);
    logic [15:0] c;
    c = crc;
    for (int i = 3; i >= 0; i--) c = ptc_crc_nib(c, w[i*4 +: 4]);
    return c;
  endfunction

endpackage

// [ptc_fifo.sv]
// answer word fifo between the frame builder and the manchester encoder
`timescale 1ns/100ps
module ptc_fifo
  import ptc_pkg::*;
#(
  parameter int W = WORD_W, // word width
  parameter int D = FIFO_D  // depth in words
) (
  input  wire logic         ref_clk,  // core clock
  input  wire logic         rstn,     // sync reset, active low
  input  wire logic         inValid,  // writer offers a word
  input  wire logic [W-1:0] inData,   // offered word
  output      logic         inReady,  // room for a word
  output      logic         outValid, // word available
  input  wire logic         outReady, // reader takes the word
  output      logic [W-1:0] outData   // head word
);
  localparam int AW = $clog2(D);

  // whole fifo state
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage
    logic [AW-1:0]       wr;  // write index
    logic [AW-1:0]       rd;  // read index
    logic [AW:0]         cnt; // words held
  } ptc_fifo_st_t;

  ptc_fifo_st_t q, d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // full and empty come straight from the count, never guessed
  always_comb begin
    inReady  = q.cnt != (AW+1)'(D);
    outValid = q.cnt != '0;
    outData  = q.mem[q.rd];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    d        = q;
    if (push) begin
      d.mem[q.wr] = inData;
      d.wr = (q.wr == AW'(D-1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) d.rd = (q.rd == AW'(D-1)) ? '0 : q.rd + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // storage keeps its contents, only the indices and the count clear
    if (!rstn) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_fifo_bound: assert property (q.cnt <= (AW+1)'(D))
    else $error("fifo count above depth");
  c_fifo_full: cover property (!inReady);
endmodule

// [ptc_core.sv]
// passive tag core: command decode, block memory, slotted manchester answer
`timescale 1ns/100ps
module ptc_core
  import ptc_pkg::*;
#(
  parameter logic [31:0] TAG_ID = 32'h1234_5678 // arbitrary value
) (
  input  wire logic       ref_clk,    // 20 MHz core clock
  input  wire logic       rstn,       // sync reset, active low
  input  wire logic       gapIn,      // field gap detected, from pin
  input  wire logic       factInit,   // factory image load, one cycle
  output      logic       modOut,     // modulation switch, high = cloak
  output      logic       tearOut,    // a block write is in progress or was interrupted
  output      logic [4:0] tearBlkOut, // block of the torn write
  output      logic       busyOut     // inside own answer slot
);

  ////////////////////////////////////////////////////////////////////////////
  // whole core state
  typedef struct packed {
    ptc_state_t                 state;   // main sequence
    logic                       g1;      // gap sync stage 1
    logic                       g2;      // gap sync stage 2
    logic                       gp;      // delayed g2, edge detect
    logic [7:0]                 div;     // half-bit divider
    logic [CNT_W-1:0]           cnt;     // gap / calibration timer
    logic [CNT_W-1:0]           slotW;   // calibrated slot width
    logic [CNT_W-1:0]           slotCnt; // cycles inside slot
    logic [3:0]                 slotIdx; // slot inside symbol
    logic                       gotNib;  // pulse seen this symbol
    logic [3:0]                 nib;     // position of that pulse
    logic [59:0]                frm;     // received nibbles
    logic [4:0]                 nibCnt;  // nibbles received
    logic [15:0]                crc;     // receive crc
    logic [HT_W-1:0]            ht;      // half-bit tick timer
    logic [4:0]                 blk;     // answered / written block
    logic [2:0]                 nWords;  // answer data words
    logic [2:0]                 idx;     // answer word index
    logic [31:0]                wData;   // block being programmed
    logic [15:0]                txCrc;   // answer crc
    logic                       txBusy;  // encoder sending
    logic                       txHalf;  // second half of bit
    logic [3:0]                 txBit;   // bit being sent
    logic [15:0]                txWord;  // word being sent
    logic                       mod;     // modulator level
    logic                       inSlot;  // own slot open
    logic                       sawCmd;  // a valid command arrived
    logic [NBLK-1:0][BLK_W-1:0] mem;     // block memory
    logic [NBLK-1:0]            lock;    // write protection
    logic                       tear;    // write in progress marker
    logic [4:0]                 tearBlk; // its block
  } ptc_core_st_t;

  ptc_core_st_t q, d;
  logic              halfTick;  // 140 kHz enable
  logic              gapRise;   // gap began
  logic              gapFall;   // gap ended
  logic              frameEnd;  // symbol without pulse closed the frame
  logic              crcOk;     // frame crc residue is zero
  logic              commit;    // programming time over
  logic              tag_first_mode;       // tag_first_mode selected
  logic              writeOk;   // addressed block accepts writes
  logic [31:0]       cfg;       // configuration block
  logic [4:0]        rdBlk;     // block of current answer word
  logic [31:0]       rdData;    // contents of that block
  logic [15:0]       pushWord;  // word offered to the fifo
  logic              pushValid; // offer valid
  logic              pushReady; // fifo has room
  logic              popValid;  // fifo has a word
  logic              popReady;  // encoder takes a word
  logic [15:0]       popWord;   // head word
  logic [HT_W-1:0]   slotWait;  // half-ticks before own slot
  ptc_cmd_t          cmd;       // decoded frame

  // reserved blocks read as zero
  function automatic logic [31:0] readBlk(
    input logic [NBLK-1:0][BLK_W-1:0] m, input logic [4:0] b);
    return (b >= 5'(RSV_FIRST)) ? 32'h0000_0000 : m[b];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // answer buffer; the builder stalls while it is full
  ptc_fifo #(.W(WORD_W), .D(FIFO_D)) uFifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (pushValid),
    .inData   (pushWord),
    .inReady  (pushReady),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode of the frame and answer words
  always_comb begin
    cfg      = q.mem[CFG_BLK];
    tag_first_mode      = cfg[TF_POS] && cfg[FR_POS];
    halfTick = q.div == 8'h00;
    gapRise  = q.g2 && !q.gp;
    gapFall  = !q.g2 && q.gp;
    // short frames sit in the low 28 bits, long frames fill all 60
    if (q.nibCnt == LONG_NIB) cmd = '{q.frm[59:56], q.frm[52:48],
                                      q.frm[47:16]};
    else cmd = '{q.frm[27:24], q.frm[20:16], 32'h0000_0000};
    crcOk    = q.crc == 16'h0000;
    frameEnd = q.state == S_SYM && !q.gotNib && q.slotIdx == 4'hF
               && q.slotCnt + 1'b1 >= q.slotW;
    writeOk  = cmd.blk != 5'(TAG_BLK) && cmd.blk < 5'(RSV_FIRST)
               && (!q.lock[cmd.blk] || cmd.blk == 5'(CFG_BLK));
    commit   = q.state == S_WRITE && halfTick
               && q.ht == HT_W'(WRITE_HT - 1);
    slotWait = cfg[MULTI_POS] ? HT_W'(cfg[SLOTN_POS +: 4] * SLOT_HT)
                              : '0;
    rdBlk    = q.blk + 5'(q.idx[2:1]);
    pushValid = q.state == S_PUSH;
    rdData    = readBlk(q.mem, rdBlk);
    if (q.idx == q.nWords) pushWord = q.txCrc;
    else if (q.idx[0]) pushWord = rdData[15:0];
    else pushWord = rdData[31:16];
    // next word joins the current one without a gap
    popReady = halfTick && (!q.txBusy || (q.txHalf && q.txBit == 4'h0));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d    = q;
    d.g1 = gapIn;
    d.g2 = q.g1;
    d.gp = q.g2;
    d.div = halfTick ? 8'(HALF_CYC - 1) : q.div - 8'h01;
    if (q.cnt != '1) d.cnt = q.cnt + 1'b1;
    unique case (q.state)
      S_BOOT: begin
        // power-up: only tag_first_mode may speak unasked
        if (tag_first_mode) begin
          d.blk = 5'(CFG_BLK);
          d.nWords = 3'(FR_WORDS);
          d.ht = '0;
          d.state = S_SLOT;
        end else d.state = S_IDLE;
      end
      S_IDLE: if (gapRise) begin
        d.cnt = '0;
        d.state = S_GAP;
      end
      S_GAP: if (gapFall) begin
        // a long lone gap is the fast-read command, a short one calibrates
        if (q.cnt >= CNT_W'(FRGAP_CYC)) begin
          d.sawCmd = 1'b1;
          d.blk = 5'(CFG_BLK);
          d.nWords = 3'(FR_WORDS);
          d.ht = '0;
          d.state = S_SLOT;
        end else d.state = S_CAL;
      end
      S_CAL: begin
        // gap to gap is one symbol; a sixteenth of it is one slot
        if (gapRise) begin
          // the timer reads one less than the rise-to-rise span
          d.slotW = (q.cnt + 1'b1) >> 4;
          d.slotCnt = '0;
          d.slotIdx = 4'h0;
          d.gotNib = 1'b0;
          d.nibCnt = 5'h00;
          d.crc = CRC_INIT;
          d.state = S_SYM;
        end else if (q.cnt == '1) d.state = S_IDLE;
      end
      S_SYM: begin
        // pulse position inside the symbol gives the nibble
        if (gapRise && !q.gotNib) begin
          d.gotNib = 1'b1;
          d.nib = q.slotIdx;
        end
        d.slotCnt = q.slotCnt + 1'b1;
        if (q.slotCnt + 1'b1 >= q.slotW) begin
          d.slotCnt = '0;
          d.slotIdx = q.slotIdx + 4'h1;
          if (q.slotIdx == 4'hF && q.gotNib) begin
            d.frm = {q.frm[55:0], q.nib};
            d.crc = ptc_crc_nib(q.crc, q.nib);
            d.gotNib = 1'b0;
            if (q.nibCnt != 5'h1F) d.nibCnt = q.nibCnt + 5'h01;
          end
        end
        if (frameEnd) begin
          d.state = S_IDLE;
          d.blk = cmd.blk;
          d.ht = '0;
          if (crcOk && q.nibCnt == SHORT_NIB && cmd.op == OP_READ) begin
            d.sawCmd = 1'b1;
            d.nWords = 3'(BLK_WORDS);
            d.state = S_SLOT;
          end else if (crcOk && q.nibCnt == SHORT_NIB
                       && cmd.op == OP_LOCK) begin
            d.sawCmd = 1'b1;
            d.lock[cmd.blk] = 1'b1;
          end else if (crcOk && q.nibCnt == LONG_NIB
                       && cmd.op == OP_WRITE && writeOk) begin
            // the torn marker is raised on the same edge that programming starts
            d.sawCmd = 1'b1;
            d.tear = 1'b1;
            d.tearBlk = cmd.blk;
            d.wData = cmd.data;
            if (q.lock[cmd.blk]) d.wData = (q.mem[cmd.blk] & ~B0_FREE)
                                           | (cmd.data & B0_FREE);
            d.state = S_WRITE;
          end
        end
      end
      S_SLOT: begin
        // silent until own slot opens
        if (q.ht >= slotWait) begin
          d.inSlot = 1'b1;
          d.idx = 3'h0;
          d.txCrc = CRC_INIT;
          d.state = S_PUSH;
        end else if (halfTick) d.ht = q.ht + 1'b1;
      end
      S_PUSH: if (pushReady) begin
        d.idx = q.idx + 3'h1;
        d.txCrc = ptc_crc_word(q.txCrc, pushWord);
        if (q.idx == q.nWords) d.state = S_DRAIN;
      end
      S_DRAIN: if (!popValid && !q.txBusy) begin
        d.inSlot = 1'b0;
        d.state = S_IDLE;
      end
      S_WRITE: begin
        // programming time counted on the internal tick
        if (halfTick) d.ht = q.ht + 1'b1;
        if (commit) begin
          d.mem[q.blk] = q.wData;
          d.tear = 1'b0;
          d.state = S_IDLE;
        end
      end
    endcase
    ////////////////////////////////////////////////////////////////////////
    // manchester encoder: bit level in first half, inverse in second
    if (halfTick) begin
      if (popReady && popValid) begin
        d.txWord = popWord;
        d.txBit = 4'hF;
        d.txHalf = 1'b0;
        d.txBusy = 1'b1;
        d.mod = popWord[15] && q.inSlot;
      end else if (q.txBusy && !q.txHalf) begin
        d.txHalf = 1'b1;
        d.mod = !q.txWord[q.txBit] && q.inSlot;
      end else if (q.txBusy && q.txBit != 4'h0) begin
        d.txBit = q.txBit - 4'h1;
        d.txHalf = 1'b0;
        d.mod = q.txWord[q.txBit - 4'h1] && q.inSlot;
      end else begin
        d.txBusy = 1'b0;
        d.mod = 1'b0;
      end
    end
    // factory image: config, identifier, nothing protected
    if (factInit) begin
      d.mem = '0;
      d.mem[CFG_BLK] = CFG_RESET;
      d.mem[TAG_BLK] = TAG_ID;
      d.lock = '0;
      d.tear = 1'b0;
    end
    // reset keeps memory, protection and the torn marker: they model
    // nonvolatile cells, so a write cut by power loss stays visible
    if (!rstn) begin
      d = '0;
      d.state = S_BOOT;
      d.div = 8'(HALF_CYC - 1);
      d.mem = q.mem;
      d.lock = q.lock;
      d.tear = q.tear;
      d.tearBlk = q.tearBlk;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign modOut     = q.mod;
  assign tearOut    = q.tear;
  assign tearBlkOut = q.tearBlk;
  assign busyOut    = q.inSlot;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int WR_MIN = (WRITE_HT - 1) * HALF_CYC;
  int wrCyc; // cycles spent programming
  always_ff @(posedge ref_clk) begin
    if (!rstn || q.state != S_WRITE) wrCyc <= 0;
    else wrCyc <= wrCyc + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_mod_out_slot: assert property (modOut |-> busyOut)
    else $error("modulation outside own slot");
  a_silent_itf: assert property (modOut |-> (q.sawCmd || tag_first_mode))
    else $error("answer without command in reader_first_mode");
  a_tag_id_fixed: assert property (!factInit |=>
    $stable(q.mem[TAG_BLK])) else $error("tag identifier changed");
  a_mod_on_tick: assert property ($changed(modOut) |->
    $past(halfTick)) else $error("modulation off the half-bit tick");
  a_manch_mid: assert property ((halfTick && q.txBusy && !q.txHalf)
    |=> modOut != $past(modOut)) else $error("no mid-bit transition");
  a_write_time: assert property (commit |-> wrCyc >= WR_MIN)
    else $error("block programmed too early");
  a_crc_drop: assert property ((frameEnd && !crcOk) |=>
    (q.state == S_IDLE && $stable(q.mem) && !q.inSlot))
    else $error("bad crc frame acted on");
  a_ttf_boot: assert property ((q.state == S_BOOT && tag_first_mode) |=>
    q.state == S_SLOT) else $error("tag_first_mode did not answer");
  a_tear_mark: assert property ((q.state == S_WRITE) |->
    (tearOut && tearBlkOut == q.blk)) else $error("write not marked");
  a_lock_hold: assert property (commit |-> (!q.lock[q.blk]
    || q.blk == 5'(CFG_BLK))) else $error("protected block written");

  c_write_done: cover property (commit);
  c_fast_read: cover property (q.state == S_GAP && gapFall
    && q.cnt >= CNT_W'(FRGAP_CYC));
  c_read_ans: cover property (q.state == S_DRAIN && q.nWords == 3'h2);
  c_crc_bad: cover property (frameEnd && !crcOk);
endmodule

// [ptc_reader.sv]
// reader model: calibration gaps, 1-of-16 pulse-position frame with crc
`timescale 1ns/100ps
module ptc_reader (
  input  wire logic ref_clk, // core clock
  output      logic gapIn    // field gap, high = carrier off
);
  localparam int SLOT = 10; // slot width in cycles, symbol is 16 slots
  localparam int PW   = 4;  // gap pulse width in cycles
  initial gapIn = 1'b0;     // carrier on while idle

  ////////////////////////////////////////////////////////////////////////////
  // crc-16 over one nibble, msb first
  function automatic logic [15:0] crc4(input logic [15:0] c,
                                       input logic [3:0]  n);
    for (int i = 3; i >= 0; i--)
      c = (c[15] ^ n[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction

  // short gap, well below the fast-read width; under half a slot so a
  // pulse in slot 0 still clears the calibration pulse before it
  task automatic pulse();
    gapIn <= 1'b1;
    repeat (PW) @(posedge ref_clk);
    gapIn <= 1'b0;
  endtask

  // frame: nibble 0 at the top of f, n nibbles with the crc in the last 4
  task automatic send(input logic [59:0] f, input int n, input logic bad);
    logic [15:0] c;
    logic [3:0]  nib;
    c = 16'hFFFF;
    for (int k = 0; k < n - 4; k++) c = crc4(c, f[59 - 4*k -: 4]);
    f[59 - 4*(n-4) -: 16] = c ^ {15'h0000, bad};
    @(posedge ref_clk);
    pulse();
    repeat (16*SLOT - PW) @(posedge ref_clk);
    // the second calibration rise also opens symbol 0
    pulse();
    for (int k = 0; k < n; k++) begin
      nib = f[59 - 4*k -: 4];
      repeat (nib*SLOT + 5 - PW) @(posedge ref_clk);
      pulse();
      repeat (16*SLOT - nib*SLOT - 5) @(posedge ref_clk);
    end
    // one empty symbol closes the frame; return before the answer starts
    repeat (16*SLOT) @(posedge ref_clk);
  endtask
endmodule

// [tb_ptc_core.sv]
// self-checking bench of the passive tag core against a reader model
`timescale 1ns/100ps
module tb_ptc_core;
  localparam logic [31:0] ID = 32'hC3A5_0F96; // arbitrary value
  logic refClk, rstn, factInit, gapIn;       // stimulus
  logic modOut, tearOut, busyOut;            // observed flags
  logic [4:0] tearBlkOut;                    // torn block number
  int miscompares = 0;                       // mismatches seen
  int checkCount = 0;                        // comparisons made

  ptc_core #(.TAG_ID(ID)) u_dut (.ref_clk(refClk), .rstn(rstn),
    .gapIn(gapIn), .factInit(factInit), .modOut(modOut),
    .tearOut(tearOut), .tearBlkOut(tearBlkOut), .busyOut(busyOut));
  ptc_reader u_rdr (.ref_clk(refClk), .gapIn(gapIn));

  initial begin
    refClk = 1'b0;
    forever #25 refClk = ~refClk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watch n cycles; report whether a flag ever left zero
  task automatic quiet(input string what, input int n, ref logic s);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(negedge refClk);
      if (s !== 1'b0) hit = 1'b1;
    end
    check(what, hit, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reader-first part stays silent with no command
  task automatic t_silent();
    quiet("silent modulator", 3000, modOut);
    check("no torn write", tearOut, 0);
    $display("test silent done");
  endtask

  // corrupted crc and a write to the identifier are both dropped
  task automatic t_dropped();
    u_rdr.send(60'h101_0000_0000_0000, 7, 1'b1);
    quiet("bad crc answer", 2000, busyOut);
    u_rdr.send(60'h201_FFFF_FFFF_0000, 15, 1'b0);
    quiet("id write start", 2000, tearOut);
    $display("test dropped done");
  endtask

  // locking a user block answers nothing, and the block refuses a later write
  task automatic t_locked();
    u_rdr.send(60'h304_0000_0000_0000, 7, 1'b0);
    quiet("lock answer", 500, busyOut);
    u_rdr.send({12'h204, 32'h0000_FFFF, 16'h0000}, 15, 1'b0);
    quiet("locked write", 1000, tearOut);
    $display("test locked done");
  endtask

  // read of the identifier block, manchester decoded at half-bit centres
  task automatic t_read();
    logic [47:0] got;
    logic [15:0] c;
    logic h, bad;
    int t;
    bad = 1'b0;
    c = 16'hFFFF;
    for (int k = 7; k >= 0; k--) c = u_rdr.crc4(c, ID[4*k +: 4]);
    u_rdr.send(60'h101_0000_0000_0000, 7, 1'b0);
    for (t = 0; t < 3000 && busyOut !== 1'b1; t++) @(negedge refClk);
    check("answer slot", busyOut, 1);
    for (t = 0; t < 400 && modOut !== 1'b1; t++) @(negedge refClk);
    repeat (71) @(negedge refClk);
    for (int i = 47; i >= 0; i--) begin
      h = modOut;
      got[i] = h;
      repeat (142) @(negedge refClk);
      if (modOut !== ~h) bad = 1'b1;
      repeat (142) @(negedge refClk);
    end
    check("manchester halves", bad, 0);
    check("tag id", got[47:16], ID);
    check("answer crc", got[15:0], c);
    repeat (300) @(negedge refClk);
    check("slot closed", busyOut, 0);
    $display("test read done");
  endtask

  // user block write opens the tear marker and sends nothing back
  task automatic t_write();
    int t;
    u_rdr.send({12'h203, 32'hA5A5_1234, 16'h0000}, 15, 1'b0);
    for (t = 0; t < 500 && tearOut !== 1'b1; t++) @(negedge refClk);
    check("tear marker", tearOut, 1);
    check("tear block", tearBlkOut, 3);
    quiet("write answer", 1000, modOut);
    $display("test write done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset, factory image, second reset so boot sees the cleared config
  initial begin
    rstn = 1'b0;
    factInit = 1'b0;
    // image loads on the first edge out of reset, but boot on that edge
    // still reads the unknown memory contents
    repeat (3) @(posedge refClk);
    rstn <= 1'b1;
    factInit <= 1'b1;
    @(posedge refClk);
    factInit <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge refClk);
    rstn <= 1'b1;
    t_silent();
    t_dropped();
    t_locked();
    t_read();
    t_write();
    tally_and_finish();
  end

  // hang guard, about twice the expected run
  initial begin
    repeat (80000) @(posedge refClk);
    miscompares++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
